// ==== core/zcd_pkg.sv ====
`default_nettype none
package zcd_pkg;

	// Register map, byte addresses on the plain register port
	localparam logic [7:0] ZCD_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ZCD_ADDR_FLAG   = 8'h04;
	localparam logic [7:0] ZCD_ADDR_IRQ_EN = 8'h08;

	// Control register field positions
	localparam int ZCD_CTRL_SW_EN   = 7;
	localparam int ZCD_CTRL_OUT     = 5;
	localparam int ZCD_CTRL_INVERT  = 4;
	localparam int ZCD_CTRL_RISE_EN = 1;
	localparam int ZCD_CTRL_FALL_EN = 0;

	// Flag register field positions
	localparam int ZCD_FLAG_CROSS   = 0;

	// Interrupt enable register field positions
	localparam int ZCD_IEN_CROSS    = 0;
	localparam int ZCD_IEN_PERIPH   = 1;
	localparam int ZCD_IEN_GLOBAL   = 2;

	localparam logic [7:0] ZCD_RDATA_ZERO = 8'h00;

	// Software-visible control fields
	typedef struct packed {
		logic software_detector_enable;
		logic output_invert;
		logic rise_irq_enable;
		logic fall_irq_enable;
	} zcd_ctrl_t;

	// Processor-side interrupt gating
	typedef struct packed {
		logic crossing_irq_enable;
		logic periph_irq_enable;
		logic global_irq_enable;
	} zcd_irq_en_t;

	localparam zcd_ctrl_t   ZCD_CTRL_RESET   = '{1'b0, 1'b0, 1'b0, 1'b0};
	localparam zcd_irq_en_t ZCD_IRQ_EN_RESET = '{1'b0, 1'b0, 1'b0};

endpackage
`default_nettype wire

// ==== core/zcd_logic.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// R01: Logic output is high while pin sinks, low while it sources; readable status.
// R02: Raw input is the analog sink-active decision, pin above crossing reference.
// R03: Output invert setting one flips the logic output polarity.
// R04: Edge detectors watch the output after inversion.
// R05: Separate rising and falling edge detectors on the logic output.
// R06: Flag sets on rising edge with rise enable, or falling with fall enable.
// R07: Processor request needs flag, crossing, peripheral and global enables all set.
// R08: Writing a new invert value can set the flag even with detector disabled.
// R09: Software clears the crossing flag; hardware never clears it.
// R10: Edge in the clearing cycle wins; flag stays set.
// R11: Logic output offered to gated and period timers as gate, clock, reset.
// R12: Fuse cleared means always enabled; fuse set means software enable decides.
// R13: Current drive and interrupt logic keep running in sleep.
// R14: Raw decision passes a two-flop synchroniser before inversion and edges.
module zcd_logic
	import zcd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_write_i,
	input  wire logic       reg_read_i,
	output logic      [7:0] reg_rdata_o,
	// Analog front end and configuration
	input  wire logic       sink_active_i,
	input  wire logic       detector_fuse_i,
	input  wire logic       sleep_i,
	output logic            pin_drive_enable_o,
	// Logic output to timers and interrupt request
	output logic            crossing_out_o,
	output logic            irq_o
);

	logic        sync1_q;
	logic        sync2_q;
	logic        fuse1_q;
	logic        fuse2_q;
	zcd_ctrl_t   ctrl_q;
	zcd_irq_en_t ien_q;
	logic        flag_q;
	logic        flag_d;
	logic        out_q;
	logic        out_d;
	logic        enabled;
	logic        rise_hit;
	logic        fall_hit;
	logic        wr_ctrl;
	logic        wr_flag;
	logic        wr_ien;

	// Exact match, so no register shows up at an alias address
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
		addr_is = (addr == target);
	endfunction

	// Sleep has no effect: drive and interrupts stay live
	logic        unused_sleep;
	assign unused_sleep = sleep_i; // R13

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= sink_active_i; // R02
			sync2_q <= sync1_q; // R14
		end
	end

	// Fuse is a static strap but still crosses in cleanly
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fuse1_q <= 1'b0;
			fuse2_q <= 1'b0;
		end else begin
			fuse1_q <= detector_fuse_i;
			fuse2_q <= fuse1_q;
		end
	end

	assign enabled = !fuse2_q || ctrl_q.software_detector_enable; // R12

	// Disabled detector reads as sourcing, so an invert write still flips the output
	assign out_d = (enabled & sync2_q) ^ ctrl_q.output_invert; // R01 R03 R08

	assign rise_hit = out_d & ~out_q; // R04 R05
	assign fall_hit = ~out_d & out_q; // R05

	assign wr_ctrl = reg_write_i && addr_is(reg_addr_i, ZCD_ADDR_CTRL);
	assign wr_flag = reg_write_i && addr_is(reg_addr_i, ZCD_ADDR_FLAG);
	assign wr_ien  = reg_write_i && addr_is(reg_addr_i, ZCD_ADDR_IRQ_EN);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= ZCD_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q.software_detector_enable <= reg_wdata_i[ZCD_CTRL_SW_EN];
			ctrl_q.output_invert            <= reg_wdata_i[ZCD_CTRL_INVERT];
			ctrl_q.rise_irq_enable          <= reg_wdata_i[ZCD_CTRL_RISE_EN];
			ctrl_q.fall_irq_enable          <= reg_wdata_i[ZCD_CTRL_FALL_EN];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ien_q <= ZCD_IRQ_EN_RESET;
		end else if (wr_ien) begin
			ien_q.crossing_irq_enable <= reg_wdata_i[ZCD_IEN_CROSS];
			ien_q.periph_irq_enable   <= reg_wdata_i[ZCD_IEN_PERIPH];
			ien_q.global_irq_enable   <= reg_wdata_i[ZCD_IEN_GLOBAL];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d; // R11
		end
	end

	// Clear is write-one; a set in the same cycle takes priority
	always_comb begin
		flag_d = flag_q;
		if (wr_flag && reg_wdata_i[ZCD_FLAG_CROSS]) begin
			flag_d = 1'b0; // R09
		end
		if ((rise_hit && ctrl_q.rise_irq_enable) || (fall_hit && ctrl_q.fall_irq_enable)) begin
			flag_d = 1'b1; // R06 R10
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= flag_q && ien_q.crossing_irq_enable
				&& ien_q.periph_irq_enable && ien_q.global_irq_enable; // R07
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_drive_enable_o <= 1'b0;
		end else begin
			pin_drive_enable_o <= enabled; // R12
		end
	end

	assign crossing_out_o = out_q; // R11

	// Read data lands one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= ZCD_RDATA_ZERO;
		end else begin
			reg_rdata_o <= ZCD_RDATA_ZERO;
			if (reg_read_i) begin
				if (addr_is(reg_addr_i, ZCD_ADDR_CTRL)) begin
					reg_rdata_o[ZCD_CTRL_SW_EN]   <= ctrl_q.software_detector_enable;
					reg_rdata_o[ZCD_CTRL_OUT]     <= out_q; // R01
					reg_rdata_o[ZCD_CTRL_INVERT]  <= ctrl_q.output_invert;
					reg_rdata_o[ZCD_CTRL_RISE_EN] <= ctrl_q.rise_irq_enable;
					reg_rdata_o[ZCD_CTRL_FALL_EN] <= ctrl_q.fall_irq_enable;
				end else if (addr_is(reg_addr_i, ZCD_ADDR_FLAG)) begin
					reg_rdata_o[ZCD_FLAG_CROSS] <= flag_q;
				end else if (addr_is(reg_addr_i, ZCD_ADDR_IRQ_EN)) begin
					reg_rdata_o[ZCD_IEN_CROSS]  <= ien_q.crossing_irq_enable;
					reg_rdata_o[ZCD_IEN_PERIPH] <= ien_q.periph_irq_enable;
					reg_rdata_o[ZCD_IEN_GLOBAL] <= ien_q.global_irq_enable;
				end
			end
		end
	end

endmodule // zcd_logic
`default_nettype wire

// ==== verification/zcd_wave_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module zcd_wave_model (
	// Waveform level and sink decision
	input  wire logic above_i,
	output logic      sink_active_o
);
	// Async delay keeps the decision off the clock edge
	assign #3 sink_active_o = above_i;
endmodule // zcd_wave_model
`default_nettype wire

// ==== verification/zcd_logic_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module zcd_logic_chk
	import zcd_pkg::*;
(
	// Watched ports
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_write_i,
	input wire logic       reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       sink_active_i,
	input wire logic       detector_fuse_i,
	input wire logic       pin_drive_enable_o,
	input wire logic       crossing_out_o,
	input wire logic       irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_idle; !$past(reg_read_i) |-> reg_rdata_o == 8'h00; endproperty
	property p_unmap; reg_read_i && reg_addr_i == 8'h0c |=> reg_rdata_o == 8'h00; endproperty
	property p_fbits; reg_read_i && reg_addr_i == ZCD_ADDR_FLAG |=> reg_rdata_o[7:1] == 7'h00; endproperty
	property p_stat;
		reg_read_i && reg_addr_i == ZCD_ADDR_CTRL |=> reg_rdata_o[ZCD_CTRL_OUT] == $past(crossing_out_o);
	endproperty
	// Reset term: flops restart from zero, so the first change needs no input edge
	property p_out;
		$changed(crossing_out_o) |-> $past(sink_active_i, 3) != $past(sink_active_i, 4) || $past(reg_write_i, 2)
			|| $past(detector_fuse_i, 3) != $past(detector_fuse_i, 4) || !$past(rst_n_i, 4);
	endproperty
	property p_rise;
		$rose(irq_o) |-> $past(crossing_out_o) != $past(crossing_out_o, 2) || $past(reg_write_i, 2);
	endproperty
	property p_fall; $fell(irq_o) |-> $past(reg_write_i, 2); endproperty
	property p_drv; !$past(detector_fuse_i, 3) && $past(rst_n_i, 4) |-> pin_drive_enable_o; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer cycle");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_fbits: assert property (p_fbits) else $error("flag spare bits set");
	a_stat: assert property (p_stat) else $error("status bit differs from output");
	a_out: assert property (p_out) else $error("output changed without cause");
	a_rise: assert property (p_rise) else $error("irq rose without edge");
	a_fall: assert property (p_fall) else $error("irq fell without write");
	a_drv: assert property (p_drv) else $error("fuse clear but not enabled");
	c_irq: cover property ($rose(irq_o));
	c_fall: cover property ($fell(irq_o));
	c_out: cover property ($changed(crossing_out_o));
endmodule // zcd_logic_chk
bind zcd_logic zcd_logic_chk u_zcd_logic_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
	.sink_active_i(sink_active_i), .detector_fuse_i(detector_fuse_i), .pin_drive_enable_o(pin_drive_enable_o),
	.crossing_out_o(crossing_out_o), .irq_o(irq_o));
`default_nettype wire

// ==== verification/test_zcd_logic.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_zcd_logic;
	import zcd_pkg::*;
	logic       clk_sys_i = 0, rst_n_i = 0, wr = 0, rd = 0, above = 0, fuse = 0, sleep = 0, sink, drv, out, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	int         n_errors = 0, checks_done = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	zcd_wave_model u_zcd_wave_model (.above_i(above), .sink_active_o(sink));
	// Sleep raised mid-run: logic must behave as awake
	zcd_logic u_zcd_logic (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .sink_active_i(sink), .detector_fuse_i(fuse),
		.sleep_i(sleep), .pin_drive_enable_o(drv), .crossing_out_o(out), .irq_o(irq));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrt(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk_sys_i) wr <= 0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i) {addr, rd} <= {a, 1'b1};
		@(posedge clk_sys_i) rd <= 0;
		#1 chk(nm, rdata, exp);
	endtask
	task automatic wave(input logic v);
		@(posedge clk_sys_i) above <= v;
		repeat (6) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1;
		wrt(ZCD_ADDR_CTRL, 8'h02);
		wave(1);
		rdc("flag", ZCD_ADDR_FLAG, 8'h01);
		rdc("ctrl", ZCD_ADDR_CTRL, 8'h22);
		chk("out", {7'h00, out}, 8'h01);
		wrt(ZCD_ADDR_FLAG, 8'h01);
		rdc("flag", ZCD_ADDR_FLAG, 8'h00);
		wave(0);
		rdc("flag", ZCD_ADDR_FLAG, 8'h00);
		wrt(ZCD_ADDR_IRQ_EN, 8'h07);
		wrt(ZCD_ADDR_CTRL, 8'h01);
		wave(1);
		chk("irq", {7'h00, irq}, 8'h00);
		wave(0);
		chk("irq", {7'h00, irq}, 8'h01);
		wrt(ZCD_ADDR_IRQ_EN, 8'h03);
		rdc("unmapped", 8'h0c, 8'h00);
		chk("irq", {7'h00, irq}, 8'h00);
		@(posedge clk_sys_i) sleep <= 1'b1;
		wrt(ZCD_ADDR_FLAG, 8'h01);
		wrt(ZCD_ADDR_CTRL, 8'h12);
		rdc("ctrl", ZCD_ADDR_CTRL, 8'h32);
		chk("out", {7'h00, out}, 8'h01);
		rdc("flag", ZCD_ADDR_FLAG, 8'h01);
		@(posedge clk_sys_i) fuse <= 1'b1;
		wave(1);
		chk("drive", {7'h00, drv}, 8'h00);
		chk("out", {7'h00, out}, 8'h01);
		wrt(ZCD_ADDR_FLAG, 8'h01);
		wrt(ZCD_ADDR_CTRL, 8'h01);
		rdc("flag", ZCD_ADDR_FLAG, 8'h01);
		chk("out", {7'h00, out}, 8'h00);
		wrt(ZCD_ADDR_CTRL, 8'h81);
		wave(1);
		rdc("ctrl", ZCD_ADDR_CTRL, 8'ha1);
		chk("drive", {7'h00, drv}, 8'h01);
		chk("out", {7'h00, out}, 8'h01);
		wrt(ZCD_ADDR_FLAG, 8'h01);
		rdc("flag", ZCD_ADDR_FLAG, 8'h00);
		// Clear lands on the very edge at which the falling output sets the flag
		@(posedge clk_sys_i) above <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk("out", {7'h00, out}, 8'h01);
		wrt(ZCD_ADDR_FLAG, 8'h01);
		#1 chk("out", {7'h00, out}, 8'h00);
		rdc("flag", ZCD_ADDR_FLAG, 8'h01);
		end_of_test();
	end
endmodule // test_zcd_logic
`default_nettype wire
